// file: core/ctm_pkg.sv
// Package for the dual channel capture/compare timer: map, fields, codes
package ctm_pkg;
   // ==========================================================
   // Register map (byte addresses)
   localparam logic [11:0] ADDR_START   = 12'h000;
   localparam logic [11:0] ADDR_MODE    = 12'h004;
   localparam logic [11:0] ADDR_OUTDIS  = 12'h008;
   localparam logic [11:0] ADDR_CUTOFF  = 12'h00c;
   localparam logic [2:0]  CH_BLK0      = 3'h1;    // paddr[7:5] of channel 0
   localparam logic [2:0]  CH_BLK1      = 3'h2;    // paddr[7:5] of channel 1
   // Word index inside a channel block
   localparam logic [2:0]  IDX_CTRL     = 3'h0;
   localparam logic [2:0]  IDX_IO       = 3'h1;
   localparam logic [2:0]  IDX_STATUS   = 3'h2;
   localparam logic [2:0]  IDX_CNT      = 3'h3;
   localparam logic [2:0]  IDX_GRA      = 3'h4;    // A..D follow at 4..7
   // ==========================================================
   // Field codes and reset values
   localparam logic [2:0]  CLR_FREE     = 3'h0;
   localparam logic [2:0]  CLR_ON_A     = 3'h1;
   localparam logic [2:0]  CLR_ON_B     = 3'h2;
   localparam logic [2:0]  CLR_SYNC     = 3'h3;
   localparam logic [15:0] CNT_ZERO     = 16'h0000;
   localparam logic [15:0] CNT_MAX      = 16'hffff;
   localparam logic [7:0]  OUTDIS_RST   = 8'hff;
   localparam logic [7:0]  OUTDIS_ALL   = 8'hff;
   localparam int          FILT_SAMPLES = 3;
   localparam logic [2:0]  FILT_ONES    = 3'h7;
   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      CMB_TIMER = 2'b00,   // Timer mode, per-pin capture or compare
      CMB_RSYNC = 2'b01,   // Reset synchronous PWM
      CMB_COMPL = 2'b10,   // Complementary PWM
      CMB_PWM3  = 2'b11    // Fixed period two-output PWM
   } ctm_cmb_e;
   typedef struct packed {
      logic [1:0] rsv;
      logic       osc_sel;     // Channel 0 A only: slow oscillator trigger
      logic       filt_en;     // Three-sample digital filter
      logic       reg_func;    // c/d_register_function
      logic       cap_mode;    // a/b/c/d_capture_select: 1 = input capture
      logic [1:0] edge_sel;    // 00 rising, 01 falling, 1x both
   } ctm_pin_cfg_s;
   typedef struct packed {
      ctm_cmb_e   cmb;
      logic [1:0] bfd;         // buffer_d_enable per channel
      logic [1:0] bfc;         // buffer_c_enable per channel
      logic       sync;
   } ctm_mode_s;
   typedef struct packed {
      logic       psel;
      logic       penable;
      logic       pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } ctm_apb_req_s;
endpackage

// file: core/ctm_top.sv
// Dual channel 16-bit capture/compare timer with APB register access
//
// Overview of operation
// - Register C buffers A, D buffers B
// - Capture with buffer: old A/B into C/D
// - Compare match loads A/B from buffer
// - Reset sync PWM: transfer on channel 0 A match
// - Complementary PWM: B0,A1,B1 on A0 match/underflow
// - PWM3: A0 match loads A/B of both
// - Buffered C/D flags set on their own pin edge
// - Buffered C/D flags set on compare match
// - Synchronous counter write loads both counters
// - Clear code 011b follows other channel's clear
// - Clear code 001b clears on A capture or A compare match
// - Pin drives waveform only while disable is 0
// - Low cutoff pin sets all output disables
// - Cutoff reaches pins within 1 to 2 cycles
// - Valid pin edge captures counter into register
// - Channel 0 A may capture on slow oscillator
// - Counter increments per tick (channel 1 decrements in complementary PWM), wraps at 65536
// - Start bit runs; 0 stops when stop-select set
// - Request on capture, compare match, oscillator trigger, overflow
// - Edge select; filter needs 3 matching samples
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none
module ctm_top (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [7:0]  timer_io_pin_in,
   output logic      [7:0]  timer_io_pin_out,
   output logic      [7:0]  timer_io_pin_oe_n,
   input  wire logic        cutoff_interrupt_pin_n,
   input  wire logic        slow_osc_trigger,
   output logic      [1:0]  irq_req
);
   // ==========================================================
   // Helpers
   function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                     input logic fall);
      edge_hit = sel[1] ? (rise | fall) : (sel[0] ? fall : rise);
   endfunction

   function automatic logic tick_due(input logic [1:0] div, input logic [2:0] pres);
      logic [2:0] mask;
      mask = 3'((4'h1 << div) - 4'h1);
      tick_due = ((pres & mask) == mask);
   endfunction

   // ==========================================================
   // State
   ctm_pkg::ctm_apb_req_s          req;
   ctm_pkg::ctm_mode_s             mode_r, mode_nxt;
   logic [1:0]                     start_r, start_nxt;
   logic [1:0]                     stopsel_r, stopsel_nxt;
   logic [7:0]                     outdis_r, outdis_nxt;
   logic                           cut_en_r, cut_en_nxt;
   logic [1:0][4:0]                ctrl_r, ctrl_nxt;
   logic [1:0][31:0]               io_r, io_nxt;
   logic [1:0][4:0]                flag_r, flag_nxt;
   logic [1:0][15:0]               cnt_r, cnt_nxt;
   logic [1:0][3:0][15:0]          gr_r, gr_nxt;
   logic [7:0]                     wave_r, wave_nxt;
   logic [7:0][1:0]                hist_r;
   logic [7:0]                     lvl_r, lvl_nxt;
   logic                           osc_r;
   logic [2:0]                     pres_r;
   logic [31:0]                    rdata_nxt;
   logic                           err_nxt;

   // ==========================================================
   // Bus decode; zero wait states, answer in the first access cycle
   assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                  paddr: paddr, pwdata: pwdata};
   wire       setup_ph = req.psel & ~req.penable;
   wire       wr_take  = req.psel & req.penable & pready & req.pwrite & ~pslverr;
   wire [2:0] blk      = req.paddr[7:5];
   wire [2:0] widx     = req.paddr[4:2];
   wire       glob_hit = (req.paddr[11:4] == 8'h00);
   wire       ch_hit   = (req.paddr[11:8] == 4'h0) &&
                         (blk == ctm_pkg::CH_BLK0 || blk == ctm_pkg::CH_BLK1);
   wire       ch_sel   = (blk == ctm_pkg::CH_BLK1);
   wire       unmapped = ~(glob_hit | ch_hit) | (req.paddr[1:0] != 2'b00);

   // ==========================================================
   // Pin sampling, filter and edge detection
   wire osc_edge = slow_osc_trigger ^ osc_r;
   logic [7:0] rise, fall;
   ctm_pkg::ctm_pin_cfg_s cfg [8];
   always_comb begin
      for (int p = 0; p < 8; p++) begin
         cfg[p] = ctm_pkg::ctm_pin_cfg_s'(io_r[p/4][(p%4)*8 +: 8]);
         // A level counts only once three samples agree
         if (cfg[p].filt_en)
            lvl_nxt[p] = ({hist_r[p], timer_io_pin_in[p]} == ctm_pkg::FILT_ONES) ? 1'b1 :
                         ({hist_r[p], timer_io_pin_in[p]} == 3'h0) ? 1'b0 : lvl_r[p];
         else
            lvl_nxt[p] = timer_io_pin_in[p];
         rise[p] = lvl_nxt[p] & ~lvl_r[p];
         fall[p] = ~lvl_nxt[p] & lvl_r[p];
      end
   end

   // ==========================================================
   // Events per channel and per general register
   logic [1:0][3:0] cap_ev, match;
   logic [1:0]      tick, own_clr, clr, ovf, unf, down;
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         tick[c] = start_r[c] & tick_due(ctrl_r[c][4:3], pres_r);
         down[c] = (c == 1) && (mode_r.cmb == ctm_pkg::CMB_COMPL);
         for (int j = 0; j < 4; j++) begin
            if (c == 0 && j == 0 && cfg[0].osc_sel)
               cap_ev[c][j] = cfg[0].cap_mode & osc_edge;
            else
               cap_ev[c][j] = cfg[c*4+j].cap_mode &
                              edge_hit(cfg[c*4+j].edge_sel, rise[c*4+j], fall[c*4+j]);
            match[c][j] = ~cfg[c*4+j].cap_mode & tick[c] & (cnt_r[c] == gr_r[c][j]);
         end
         own_clr[c] = (ctrl_r[c][2:0] == ctm_pkg::CLR_ON_A && (cap_ev[c][0] | match[c][0])) ||
                      (ctrl_r[c][2:0] == ctm_pkg::CLR_ON_B && (cap_ev[c][1] | match[c][1]));
         ovf[c] = tick[c] & ~down[c] & (cnt_r[c] == ctm_pkg::CNT_MAX);
         unf[c] = tick[c] & down[c] & (cnt_r[c] == ctm_pkg::CNT_ZERO);
      end
      // Synchronous clear follows only the partner's own clear, avoiding a loop
      for (int c = 0; c < 2; c++)
         clr[c] = own_clr[c] | (mode_r.sync && ctrl_r[c][2:0] == ctm_pkg::CLR_SYNC &&
                                own_clr[1-c]);
   end

   // Channel 0 A match drives the combined-mode transfers
   wire m0a = match[0][0];

   // Hardware set events per status bit; a software clear never hides one
   wire [1:0][4:0] flag_set = {ovf[1], cap_ev[1] | match[1], ovf[0], cap_ev[0] | match[0]};

   // ==========================================================
   // Next state of counters, general registers and flags
   logic [1:0] bufsel [2];
   logic       xfer;
   always_comb begin
      gr_nxt   = gr_r;
      cnt_nxt  = cnt_r;
      flag_nxt = flag_r;
      wave_nxt = wave_r;
      start_nxt = start_r;
      xfer = 1'b0;
      for (int c = 0; c < 2; c++) begin
         bufsel[c] = {mode_r.bfd[c], mode_r.bfc[c]};
         // Capture: buffer takes the old value first
         for (int j = 0; j < 2; j++) begin
            if (cap_ev[c][j]) begin
               if (bufsel[c][j])
                  gr_nxt[c][j+2] = gr_r[c][j];
               gr_nxt[c][j] = cnt_r[c];
            end
         end
         for (int j = 2; j < 4; j++)
            if (cap_ev[c][j] && !bufsel[c][j-2])
               gr_nxt[c][j] = cnt_r[c];
         // Compare transfers from buffer, timing set by the combined mode
         for (int j = 0; j < 2; j++) begin
            unique case (mode_r.cmb)
               ctm_pkg::CMB_TIMER: xfer = match[c][j];
               ctm_pkg::CMB_RSYNC: xfer = m0a;
               ctm_pkg::CMB_COMPL: xfer = (m0a | unf[1]) && !(c == 0 && j == 0);
               ctm_pkg::CMB_PWM3:  xfer = m0a;
            endcase
            if (xfer && bufsel[c][j] && !cfg[c*4+j].cap_mode)
               gr_nxt[c][j] = gr_r[c][j+2];
         end
         // Flags: C/D set on their own pin edge or their own match
         for (int j = 0; j < 4; j++) begin
            if (cap_ev[c][j] | match[c][j])
               flag_nxt[c][j] = 1'b1;
            if (match[c][j])
               wave_nxt[c*4+j] = ~wave_r[c*4+j];
         end
         if (ovf[c])
            flag_nxt[c][4] = 1'b1;
         // Counter: clear beats count
         if (clr[c])
            cnt_nxt[c] = ctm_pkg::CNT_ZERO;
         else if (tick[c])
            cnt_nxt[c] = down[c] ? cnt_r[c] - 16'h0001 : cnt_r[c] + 16'h0001;
         // Stop on A match when stop-select is 0 in compare use
         if (!stopsel_r[c] && match[c][0])
            start_nxt[c] = 1'b0;
      end
      // Software writes
      if (wr_take && ch_hit) begin
         if (widx == ctm_pkg::IDX_CNT) begin
            cnt_nxt[ch_sel] = req.pwdata[15:0];
            if (mode_r.sync)
               cnt_nxt[~ch_sel] = req.pwdata[15:0];
         end
         if (widx >= ctm_pkg::IDX_GRA)
            gr_nxt[ch_sel][widx[1:0]] = req.pwdata[15:0];
         // Write 0 clears a flag unless hardware sets it in this cycle
         if (widx == ctm_pkg::IDX_STATUS)
            for (int k = 0; k < 5; k++)
               if (!req.pwdata[k] && !flag_set[ch_sel][k])
                  flag_nxt[ch_sel][k] = 1'b0;
      end
      if (wr_take && glob_hit && req.paddr[3:0] == ctm_pkg::ADDR_START[3:0])
         for (int c = 0; c < 2; c++) begin
            if (req.pwdata[c])
               start_nxt[c] = 1'b1;
            else if (req.pwdata[c+2])
               start_nxt[c] = 1'b0;
         end
   end

   // ==========================================================
   // Configuration writes and forced cutoff
   always_comb begin
      mode_nxt    = mode_r;
      stopsel_nxt = stopsel_r;
      outdis_nxt  = outdis_r;
      cut_en_nxt  = cut_en_r;
      ctrl_nxt    = ctrl_r;
      io_nxt      = io_r;
      if (wr_take && glob_hit) begin
         unique case (req.paddr[3:0])
            ctm_pkg::ADDR_START[3:0]:  stopsel_nxt = req.pwdata[3:2];
            ctm_pkg::ADDR_MODE[3:0]:   mode_nxt = ctm_pkg::ctm_mode_s'(req.pwdata[6:0]);
            ctm_pkg::ADDR_OUTDIS[3:0]: outdis_nxt = req.pwdata[7:0];
            ctm_pkg::ADDR_CUTOFF[3:0]: cut_en_nxt = req.pwdata[0];
            default: ;
         endcase
      end
      if (wr_take && ch_hit && widx == ctm_pkg::IDX_CTRL)
         ctrl_nxt[ch_sel] = req.pwdata[4:0];
      if (wr_take && ch_hit && widx == ctm_pkg::IDX_IO)
         io_nxt[ch_sel] = req.pwdata;
      // Cutoff overrides a software write of the output disables in the same cycle
      if (cut_en_r && !cutoff_interrupt_pin_n)
         outdis_nxt = ctm_pkg::OUTDIS_ALL;
   end

   // ==========================================================
   // Read data
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      err_nxt   = unmapped;
      // A refused read returns zero, even inside a mapped block
      if (glob_hit && !unmapped) begin
         unique case (req.paddr[3:0])
            ctm_pkg::ADDR_START[3:0]:  rdata_nxt = {28'h0, stopsel_r, start_r};
            ctm_pkg::ADDR_MODE[3:0]:   rdata_nxt = {25'h0, mode_r};
            ctm_pkg::ADDR_OUTDIS[3:0]: rdata_nxt = {24'h0, outdis_r};
            ctm_pkg::ADDR_CUTOFF[3:0]: rdata_nxt = {31'h0, cut_en_r};
            default: ;
         endcase
      end else if (ch_hit && !unmapped) begin
         unique case (widx)
            ctm_pkg::IDX_CTRL:   rdata_nxt = {27'h0, ctrl_r[ch_sel]};
            ctm_pkg::IDX_IO:     rdata_nxt = io_r[ch_sel];
            ctm_pkg::IDX_STATUS: rdata_nxt = {27'h0, flag_r[ch_sel]};
            ctm_pkg::IDX_CNT:    rdata_nxt = {16'h0, cnt_r[ch_sel]};
            default:             rdata_nxt = {16'h0, gr_r[ch_sel][widx[1:0]]};
         endcase
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk) begin
      if (reset) begin
         mode_r    <= '0;
         start_r   <= '0;
         stopsel_r <= '0;
         outdis_r  <= ctm_pkg::OUTDIS_RST;
         cut_en_r  <= 1'b0;
         ctrl_r    <= '0;
         io_r      <= '0;
         flag_r    <= '0;
         cnt_r     <= '0;
         gr_r      <= '0;
         wave_r    <= '0;
      end else begin
         mode_r    <= mode_nxt;
         start_r   <= start_nxt;
         stopsel_r <= stopsel_nxt;
         outdis_r  <= outdis_nxt;
         cut_en_r  <= cut_en_nxt;
         ctrl_r    <= ctrl_nxt;
         io_r      <= io_nxt;
         flag_r    <= flag_nxt;
         cnt_r     <= cnt_nxt;
         gr_r      <= gr_nxt;
         wave_r    <= wave_nxt;
      end
   end

   // Sampling history, prescaler and oscillator edge memory
   always_ff @(posedge clk) begin
      if (reset) begin
         hist_r <= '0;
         lvl_r  <= '0;
         osc_r  <= 1'b0;
         pres_r <= '0;
      end else begin
         for (int p = 0; p < 8; p++)
            hist_r[p] <= {hist_r[p][0], timer_io_pin_in[p]};
         lvl_r  <= lvl_nxt;
         osc_r  <= slow_osc_trigger;
         pres_r <= pres_r + 3'h1;
      end
   end

   // Bus answer: ready in the first access cycle, data captured at setup
   always_ff @(posedge clk) begin
      if (reset) begin
         pready  <= 1'b0;
         prdata  <= '0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup_ph;
         pslverr <= setup_ph & err_nxt;
         if (setup_ph)
            prdata <= rdata_nxt;
      end
   end

   // Pins and requests; the disable bit is one flop ahead of the pin enable,
   // so a low cutoff pin shows at the pins on the second edge
   always_ff @(posedge clk) begin
      if (reset) begin
         timer_io_pin_out  <= '0;
         timer_io_pin_oe_n <= '1;
         irq_req           <= '0;
      end else begin
         for (int p = 0; p < 8; p++)
            timer_io_pin_oe_n[p] <= outdis_r[p] | cfg[p].cap_mode;
         timer_io_pin_out <= wave_r;
         for (int c = 0; c < 2; c++)
            irq_req[c] <= (|cap_ev[c]) | (|match[c]) | ovf[c];
      end
   end
endmodule
`default_nettype wire

// file: bench/ctm_properties.sv
// Port-level concurrent checks for the capture/compare timer
`timescale 1ns/10ps
`default_nettype none
module ctm_properties (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  timer_io_pin_oe_n,
   input wire logic        cutoff_interrupt_pin_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // ============================================================
   // Shadow of cutoff enable and disable bits, rebuilt from completed writes
   logic       cut_en_r;
   logic [7:0] dis_r;
   wire        wr_done = psel && penable && pready && pwrite;
   always_ff @(posedge clk) begin
      if (reset) begin
         cut_en_r <= 1'b0;
         dis_r    <= ctm_pkg::OUTDIS_RST;
      end else begin
         if (wr_done && paddr == ctm_pkg::ADDR_CUTOFF) cut_en_r <= pwdata[0];
         if (cut_en_r && !cutoff_interrupt_pin_n) dis_r <= ctm_pkg::OUTDIS_ALL;
         else if (wr_done && paddr == ctm_pkg::ADDR_OUTDIS) dis_r <= pwdata[7:0];
      end
   end
   // ============================================================
   // Bus handshake and refusal
   ready_on_access_a: assert property (psel && penable && !$past(penable) |-> pready)
      else $error("pready missing in first access cycle");
   ready_single_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside an access cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   err_reads_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   reset_quiet_a: assert property ($past(reset) |-> !pready && timer_io_pin_oe_n == 8'hff)
      else $error("outputs not idle after reset");
   // ============================================================
   // Forced cutoff; the hold check tolerates the two-edge pin latency
   sequence cut_low;
      cut_en_r && !cutoff_interrupt_pin_n;
   endsequence
   cut_latency_a: assert property (cut_low |-> ##[1:2] (&timer_io_pin_oe_n))
      else $error("cutoff too slow");
   cut_hold_a: assert property (cut_low [*3] |-> &timer_io_pin_oe_n)
      else $error("pin driven during cutoff");
   dis_gate_a: assert property (dis_r == $past(dis_r) && dis_r == $past(dis_r, 2) |->
      (timer_io_pin_oe_n & dis_r) == dis_r)
      else $error("disabled pin still driven");
endmodule
bind ctm_top ctm_properties ctm_properties_inst (.clk(clk), .reset(reset), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timer_io_pin_oe_n(timer_io_pin_oe_n),
   .cutoff_interrupt_pin_n(cutoff_interrupt_pin_n));
`default_nettype wire

// file: bench/ctm_pins_model.sv
// Far-side model: capture pins, cutoff pin and slow oscillator line
`timescale 1ns/10ps
`default_nettype none
module ctm_pins_model (
   input  wire logic       clk,
   output logic      [7:0] pin_lvl,
   output logic            cut_n,
   output logic            osc
);
   initial begin
      pin_lvl = 8'h00;
      cut_n   = 1'b1;
      osc     = 1'b0;
   end
   // Level is seen for n+1 samples; short holds exist only to probe the filter
   task automatic drive(input int idx, input logic lvl, input int n);
      @(posedge clk);
      pin_lvl[idx] <= lvl;
      repeat (n) @(posedge clk);
   endtask
   // Cutoff pin is an input level, set up by software before use
   task automatic cutoff(input logic lvl);
      @(posedge clk);
      cut_n <= lvl;
   endtask
   task automatic osc_edge();
      @(posedge clk);
      osc <= ~osc;
   endtask
endmodule
`default_nettype wire

// file: bench/ctm_top_tb.sv
// Self-checking bench for the dual channel capture/compare timer
`timescale 1ns/10ps
`default_nettype none
module ctm_top_tb;
   localparam logic [11:0] C0 = 12'h020;
   localparam logic [11:0] C1 = 12'h040;
   logic        clk, reset, psel, penable, pwrite, pready, pslverr, cut_n, osc, err_v;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd_v;
   logic [7:0]  pin_lvl, pin_out, oe_n;
   logic [1:0]  irq;
   int          n_fail, checks_done;
   ctm_top ctm_top_inst (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_io_pin_in(pin_lvl), .timer_io_pin_out(pin_out),
      .timer_io_pin_oe_n(oe_n), .cutoff_interrupt_pin_n(cut_n), .slow_osc_trigger(osc),
      .irq_req(irq));
   ctm_pins_model pins (.clk(clk), .pin_lvl(pin_lvl), .cut_n(cut_n), .osc(osc));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ============================================================
   // Bus and compare helpers; the watchdog bounds every wait
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd_v, exp);
   endtask
   task automatic pulse(input int i);
      pins.drive(i, 1'b1, 4);
      pins.drive(i, 1'b0, 4);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // ============================================================
   // Scenarios
   task automatic t_regs();
      rd(ctm_pkg::ADDR_OUTDIS, 32'hff);
      apb(1'b0, 12'h0fc, 32'h0);
      chk({31'h0, err_v}, 32'h1);
      chk(rd_v, 32'h0);
      $display("test regs done");
   endtask
   task automatic t_cap();
      wr(ctm_pkg::ADDR_MODE, 32'h2);
      wr(C0 + 12'h04, 32'h000c_0004);
      wr(C0 + 12'h0c, 32'h1111);
      pulse(0);
      rd(C0 + 12'h10, 32'h1111);
      wr(C0 + 12'h0c, 32'h2222);
      pulse(0);
      rd(C0 + 12'h10, 32'h2222);
      rd(C0 + 12'h18, 32'h1111);
      rd(C0 + 12'h08, 32'h1);
      pulse(2);
      rd(C0 + 12'h08, 32'h5);
      $display("test capture done");
   endtask
   task automatic t_sync();
      wr(ctm_pkg::ADDR_MODE, 32'h1);
      wr(C0, {29'h0, ctm_pkg::CLR_ON_A});
      wr(C1, {29'h0, ctm_pkg::CLR_SYNC});
      wr(C0 + 12'h0c, 32'h3456);
      rd(C1 + 12'h0c, 32'h3456);
      pulse(0);
      rd(C0 + 12'h10, 32'h3456);
      rd(C0 + 12'h0c, 32'h0);
      rd(C1 + 12'h0c, 32'h0);
      $display("test sync done");
   endtask
   task automatic t_edges();
      wr(C0, 32'h0);
      wr(C0 + 12'h04, 32'h15);
      wr(C0 + 12'h0c, 32'h0aaa);
      pins.drive(0, 1'b1, 6);
      pins.drive(0, 1'b0, 1);
      pins.drive(0, 1'b1, 6);
      rd(C0 + 12'h10, 32'h3456);
      pins.drive(0, 1'b0, 6);
      rd(C0 + 12'h10, 32'h0aaa);
      wr(C0 + 12'h04, 32'h06);
      wr(C0 + 12'h0c, 32'h0bbb);
      pins.drive(0, 1'b1, 4);
      rd(C0 + 12'h10, 32'h0bbb);
      wr(C0 + 12'h0c, 32'h0ccd);
      pins.drive(0, 1'b0, 4);
      rd(C0 + 12'h10, 32'h0ccd);
      $display("test edges done");
   endtask
   task automatic t_osc();
      logic got;
      got = 1'b0;
      wr(C0 + 12'h04, 32'h24);
      wr(C0 + 12'h0c, 32'h0ddd);
      pins.osc_edge();
      repeat (6) begin
         @(posedge clk);
         if (irq[0] === 1'b1) got = 1'b1;
      end
      chk({31'h0, got}, 32'h1);
      rd(C0 + 12'h10, 32'h0ddd);
      $display("test osc done");
   endtask
   task automatic t_run();
      logic [31:0] v;
      wr(C0 + 12'h0c, 32'hfff0);
      wr(ctm_pkg::ADDR_START, 32'h5);
      repeat (40) @(posedge clk);
      wr(ctm_pkg::ADDR_START, 32'h4);
      apb(1'b0, C0 + 12'h0c, 32'h0);
      v = rd_v;
      chk({31'h0, v > 32'h0 && v < 32'h100}, 32'h1);
      rd(C0 + 12'h0c, v);
      apb(1'b0, C0 + 12'h08, 32'h0);
      chk(rd_v & 32'h10, 32'h10);
      $display("test run done");
   endtask
   task automatic t_cut();
      wr(ctm_pkg::ADDR_OUTDIS, 32'h0);
      repeat (3) @(posedge clk);
      chk({24'h0, oe_n & 8'hf0}, 32'h0);
      wr(ctm_pkg::ADDR_CUTOFF, 32'h1);
      pins.cutoff(1'b0);
      repeat (3) @(posedge clk);
      chk({24'h0, oe_n}, 32'hff);
      pins.cutoff(1'b1);
      rd(ctm_pkg::ADDR_OUTDIS, 32'hff);
      $display("test cutoff done");
   endtask
   // Channel 1 compare with C buffering A; counter stops on the A match
   task automatic t_cmp();
      logic got;
      got = 1'b0;
      wr(ctm_pkg::ADDR_MODE, 32'h4);
      wr(C1, 32'h0);
      wr(C1 + 12'h04, 32'h0008_0000);
      wr(C1 + 12'h10, 32'h0010);
      wr(C1 + 12'h18, 32'h000e);
      wr(C1 + 12'h0c, 32'h000c);
      wr(ctm_pkg::ADDR_START, 32'h2);
      repeat (10) begin
         @(posedge clk);
         if (irq[1] === 1'b1) got = 1'b1;
      end
      chk({31'h0, got}, 32'h1);
      rd(C1 + 12'h10, 32'h000e);
      rd(C1 + 12'h08, 32'h5);
      rd(ctm_pkg::ADDR_START, 32'h0);
      chk({24'h0, pin_out & 8'hf0}, 32'h50);
      $display("test compare done");
   endtask
   // Fixed period mode: channel 0 A match reloads A of both channels
   task automatic t_pwm3();
      wr(ctm_pkg::ADDR_MODE, 32'h66);
      wr(C0 + 12'h04, 32'h0008_0000);
      wr(C0 + 12'h10, 32'h0010);
      wr(C0 + 12'h18, 32'h0030);
      wr(C1 + 12'h18, 32'h0040);
      wr(C0 + 12'h0c, 32'h000c);
      wr(ctm_pkg::ADDR_START, 32'h1);
      repeat (10) @(posedge clk);
      rd(C0 + 12'h10, 32'h0030);
      rd(C1 + 12'h10, 32'h0040);
      $display("test pwm3 done");
   endtask
   // ============================================================
   // Main sequence and watchdog
   initial begin
      n_fail = 0;
      checks_done = 0;
      reset = 1'b1;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      t_regs();
      t_cap();
      t_sync();
      t_edges();
      t_osc();
      t_run();
      t_cut();
      t_cmp();
      t_pwm3();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
